/* include/axis_supervision_regs.svh */
/*
  register indices, field positions, reset values and timing counts of the
  axis supervision block.
  assumes: included by bare name; a byte address is four times an index.
*/
`ifndef AXIS_SUPERVISION_REGS_SVH
`define AXIS_SUPERVISION_REGS_SVH

// ----------------------------------------------------------------------
// per-axis register indices
// ----------------------------------------------------------------------
`define IDX_FULL_STEPS      10'h0CA
`define IDX_FREEWHEEL       10'h0CC
`define IDX_LOAD            10'h0CE
`define IDX_STICKY_ERR      10'h0CF
`define IDX_DRV_FAULT       10'h0D0
`define IDX_ENC_COUNT       10'h0D1
`define IDX_ENC_RES         10'h0D2
`define IDX_MAX_DEV         10'h0D4
`define IDX_GROUP           10'h0D5
`define IDX_PD_DELAY        10'h0D6
`define IDX_SHAFT_INV       10'h0FB
`define IDX_UNIT_MODE       10'h0FF
// ----------------------------------------------------------------------
// block-wide interrupt registers
// ----------------------------------------------------------------------
`define IDX_IRQ_STATUS      10'h100
`define IDX_IRQ_ENABLE      10'h101
`define IDX_IRQ_CLEAR       10'h102

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define ERR_STALL_BIT       0
`define ERR_DEV_BIT         1
`define FULL_STEPS_RST      16'h00C8
`define FREEWHEEL_RST       2'h0
`define ENC_RES_RST         16'h0000
`define MAX_DEV_RST         16'h0000
`define GROUP_RST           8'h00
`define PD_DELAY_RST        9'h0C8
`define SHAFT_INV_RST       1'h0
`define UNIT_MODE_RST       1'h1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_HZ              10000000
`define PD_UNIT_MS          10
`define PD_UNIT_CYCLES      ((`PD_UNIT_MS * `CLK_HZ) / 1000)

`endif

/* include/axis_supervision_pkg.sv */
/*
  types shared by the axis supervision block.
  assumes: compiled before the design module; never imported.
*/
package axis_supervision_pkg;

  // ----------------------------------------------------------------------
  // motion commands
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    no_cmd                = 3'b000,
    rotate_right_cmd      = 3'b001,
    rotate_left_cmd       = 3'b010,
    motor_halt_cmd        = 3'b011,
    move_to_position_cmd  = 3'b100,
    reference_search_cmd  = 3'b101
  } motion_cmd_e;

  // command entering the block, addressed to one axis
  typedef struct packed {
    logic        valid;
    logic [1:0]  axis;
    motion_cmd_e code;
  } motion_req_s;

  // command leaving the block towards one axis
  typedef struct packed {
    logic        valid;
    motion_cmd_e code;
  } axis_cmd_s;

  // static configuration of one axis
  typedef struct packed {
    logic [15:0] full_steps;
    logic [15:0] enc_res;
    logic [1:0]  freewheel;
    logic        shaft_inv;
    logic        unit_pps;
  } axis_cfg_s;

  // bus slave phase
  typedef enum logic {
    bus_idle = 1'b0,
    bus_ack  = 1'b1
  } bus_state_e;

endpackage : axis_supervision_pkg

/* hdl/axis_supervision.sv */
/*
  per-axis supervision parameters: resolutions, load readout, sticky errors,
  driver faults, encoder counting and deviation stop, group command fan-out,
  standstill power-down, shaft reversal, unit mode and an interrupt.
  assumes: single 10 MHz clock, synchronous reset, avalon-mm master on the
  same clock, driver and encoder pins asynchronous to it.
*/
// Notes on behaviour
// - full-step count, 16-bit rw, default 200
// - read-only load value, 0 to 1023
// - error flags stall=1 deviation=2, clear on read
// - any motion command clears the error flags
// - fault bit0 stall, bit1 overtemperature shutdown
// - fault bit2 temperature pre-warning
// - fault bit3 phase a short to ground
// - encoder counts per revolution, 16-bit rw
// - deviation above maximum halts the motor
// - maximum deviation zero disables supervision
// - same nonzero group gets the same command
// - group zero excludes the axis
// - standstill delay in 10 ms units, then standby
// - power-down delay defaults to 200 units
// - one bit reverses shaft direction
// - unit mode 0 internal, 1 pulses per second
// - unit mode defaults to 1
`include "axis_supervision_regs.svh"

module axis_supervision #(
  parameter int unsigned NUM_AXES    = 3,
  parameter int unsigned TICK_CYCLES = `PD_UNIT_CYCLES
) (
  input  wire logic                                         i_clk_sys,
  input  wire logic                                         i_sys_rst,
  // avalon-mm slave, byte address
  input  wire logic [13:0]                                  i_avs_address,
  input  wire logic                                         i_avs_read,
  input  wire logic                                         i_avs_write,
  input  wire logic [31:0]                                  i_avs_writedata,
  input  wire logic [3:0]                                   i_avs_byteenable,
  output logic      [31:0]                                  o_avs_readdata,
  output logic                                              o_avs_waitrequest,
  // motion side, same clock
  input  wire axis_supervision_pkg::motion_req_s            i_cmd,
  input  wire logic [NUM_AXES-1:0][31:0]                    i_cmd_pos,
  input  wire logic [NUM_AXES-1:0]                          i_standstill,
  output axis_supervision_pkg::axis_cmd_s [NUM_AXES-1:0]    o_axis_cmd,
  output axis_supervision_pkg::axis_cfg_s [NUM_AXES-1:0]    o_axis_cfg,
  output logic      [NUM_AXES-1:0]                          o_power_down,
  // driver and encoder pins, asynchronous
  input  wire logic [NUM_AXES-1:0][9:0]                     i_load_pin,
  input  wire logic [NUM_AXES-1:0][7:0]                     i_fault_pin,
  input  wire logic [NUM_AXES-1:0]                          i_enc_a,
  input  wire logic [NUM_AXES-1:0]                          i_enc_b,
  // interrupt
  output logic                                              o_irq
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // merge write data into an old word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // does a write at this index hit
  function automatic logic idx_hit(input logic [9:0] idx, input logic [9:0] want);
    return idx == want;
  endfunction : idx_hit

  // ----------------------------------------------------------------------
  // bus slave: one wait cycle, then answer
  // ----------------------------------------------------------------------
  axis_supervision_pkg::bus_state_e bus_state;   // idle or answering
  axis_supervision_pkg::bus_state_e next_bus_state;
  wire logic        bus_req  = i_avs_read | i_avs_write;   // request present
  wire logic        bus_done = bus_req & (bus_state == axis_supervision_pkg::bus_ack);
  wire logic        wr_ok    = bus_done & i_avs_write;     // write takes effect
  wire logic        rd_ok    = bus_done & i_avs_read;      // read completes
  wire logic [9:0]  a_idx    = i_avs_address[11:2];        // register index
  wire logic [1:0]  a_axis   = i_avs_address[13:12];       // axis field
  logic [31:0]      rd_mux;                                // selected read value

  assign next_bus_state    = (bus_req & ~bus_done) ? axis_supervision_pkg::bus_ack
                                                   : axis_supervision_pkg::bus_idle;
  assign o_avs_waitrequest = bus_req & ~bus_done;

  // bus phase and read data capture
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bus_state      <= axis_supervision_pkg::bus_idle;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      case (bus_state)
        axis_supervision_pkg::bus_idle: begin
          if (i_avs_read) begin
            o_avs_readdata <= rd_mux;
          end
        end
        axis_supervision_pkg::bus_ack:  begin
        end
        default: begin
        end
      endcase
      bus_state <= next_bus_state;
    end
  end

  // ----------------------------------------------------------------------
  // group command fan-out and power-down prescaler
  // ----------------------------------------------------------------------
  logic [7:0]  group_id [NUM_AXES];        // per-axis group index
  logic [31:0] rd_axis  [NUM_AXES];        // per-axis read value
  logic [NUM_AXES-1:0] stall_set;          // stall event per axis
  logic [NUM_AXES-1:0] dev_trip;           // deviation stop per axis
  logic [31:0] tick_cnt;                   // 10 ms prescaler
  wire logic   pd_tick = (tick_cnt == TICK_CYCLES - 1);
  wire logic [7:0] src_group = (i_cmd.axis < NUM_AXES) ? group_id[i_cmd.axis] : 8'h00;

  // prescaler for the standstill delay unit
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || pd_tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt: sticky status, enable, write-one-to-clear
  // ----------------------------------------------------------------------
  localparam int unsigned IRQ_W = 2 * NUM_AXES;
  logic [IRQ_W-1:0] irq_status;            // sticky events
  logic [IRQ_W-1:0] irq_enable;            // mask
  logic [IRQ_W-1:0] irq_events;            // this cycle's events
  wire logic glob_sel = wr_ok & (a_axis == 2'h0);
  wire logic [IRQ_W-1:0] irq_clr = (glob_sel & idx_hit(a_idx, `IDX_IRQ_CLEAR))
                                   ? i_avs_writedata[IRQ_W-1:0] : '0;

  // status bits set over clear, enable written by software
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_events;
      if (glob_sel && idx_hit(a_idx, `IDX_IRQ_ENABLE)) begin
        irq_enable <= i_avs_writedata[IRQ_W-1:0];
      end
    end
  end
  assign o_irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------------
  wire logic [31:0] rd_glob =
      (a_idx == `IDX_IRQ_STATUS) ? 32'(irq_status) :
      (a_idx == `IDX_IRQ_ENABLE) ? 32'(irq_enable) : 32'h0000_0000;
  wire logic glob_idx = (a_idx == `IDX_IRQ_STATUS) || (a_idx == `IDX_IRQ_ENABLE);
  assign rd_mux = glob_idx ? ((a_axis == 2'h0) ? rd_glob : 32'h0000_0000)
                : (a_axis < NUM_AXES) ? rd_axis[a_axis] : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // per-axis logic
  // ----------------------------------------------------------------------
  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    logic [15:0] full_steps;          // full steps per revolution
    logic [1:0]  freewheel;           // standstill option
    logic [15:0] enc_res;             // encoder counts per revolution
    logic [15:0] max_dev;             // deviation limit, zero is off
    logic [8:0]  pd_delay;            // standstill delay, 10 ms units
    logic        shaft_inv;           // direction reversal
    logic        unit_pps;            // velocity unit mode
    logic [1:0]  err_flags;           // sticky stall and deviation
    logic [31:0] enc_count;           // signed encoder position
    logic [9:0]  load_s1, load_s2;    // load value synchroniser
    logic [7:0]  fault_s1, fault_s2;  // fault byte synchroniser
    logic [1:0]  enc_s1, enc_s2;      // encoder pin synchroniser
    logic [1:0]  enc_prev;            // previous synced encoder state
    logic        stall_prev;          // stall level one cycle ago
    logic        dev_over_q;          // deviation level one cycle ago
    logic [8:0]  pd_cnt;              // standstill unit counter
    logic [7:0]  group_reg;           // group index storage
    logic [9:0]  load_s3;             // third load stage, for agreement
    logic [9:0]  load_val;            // load word once two samples agree
    localparam logic [1:0] AX = 2'(a); // this axis as an address field

    wire logic sel    = wr_ok & (a_axis == AX);
    wire logic [31:0] wdata = i_avs_writedata;
    // command reaching this axis, directly or through its group
    wire logic cmd_hit = i_cmd.valid && (i_cmd.code != axis_supervision_pkg::no_cmd)
                         && ((i_cmd.axis == AX)
                         || ((group_id[a] != 8'h00) && (group_id[a] == src_group)));
    // deviation between commanded and encoder position
    wire logic [31:0] diff    = i_cmd_pos[a] - enc_count;
    wire logic [31:0] absdiff = diff[31] ? (32'h0000_0000 - diff) : diff;
    wire logic dev_over = (max_dev != 16'h0000) && (absdiff > {16'h0000, max_dev});
    wire logic clr_read = rd_ok && (a_axis == AX) && (a_idx == `IDX_STICKY_ERR);
    wire logic [1:0] err_set = {dev_trip[a], stall_set[a]};
    wire logic enc_step = (enc_s2[1] ^ enc_prev[1]) | (enc_s2[0] ^ enc_prev[0]);
    wire logic enc_up   = enc_s2[1] ^ enc_prev[0];
    // byte-lane merges of the wider registers
    wire logic [31:0] m_steps = be_merge({16'h0000, full_steps}, wdata, i_avs_byteenable);
    wire logic [31:0] m_res   = be_merge({16'h0000, enc_res}, wdata, i_avs_byteenable);
    wire logic [31:0] m_dev   = be_merge({16'h0000, max_dev}, wdata, i_avs_byteenable);
    wire logic [31:0] m_delay = be_merge({23'h00_0000, pd_delay}, wdata, i_avs_byteenable);

    assign stall_set[a] = fault_s2[0] & ~stall_prev;
    assign dev_trip[a]  = dev_over & ~dev_over_q;
    assign irq_events[2*a +: 2] = err_set;
    assign group_id[a]  = group_reg;

    // readable value at the selected index
    assign rd_axis[a] =
        (a_idx == `IDX_FULL_STEPS) ? {16'h0000, full_steps} :
        (a_idx == `IDX_FREEWHEEL)  ? {30'h0000_0000, freewheel} :
        (a_idx == `IDX_LOAD)       ? {22'h00_0000, load_val} :
        (a_idx == `IDX_STICKY_ERR) ? {30'h0000_0000, err_flags} :
        (a_idx == `IDX_DRV_FAULT)  ? {24'h00_0000, fault_s2} :
        (a_idx == `IDX_ENC_COUNT)  ? enc_count :
        (a_idx == `IDX_ENC_RES)    ? {16'h0000, enc_res} :
        (a_idx == `IDX_MAX_DEV)    ? {16'h0000, max_dev} :
        (a_idx == `IDX_GROUP)      ? {24'h00_0000, group_reg} :
        (a_idx == `IDX_PD_DELAY)   ? {23'h00_0000, pd_delay} :
        (a_idx == `IDX_SHAFT_INV)  ? {31'h0000_0000, shaft_inv} :
        (a_idx == `IDX_UNIT_MODE)  ? {31'h0000_0000, unit_pps} : 32'h0000_0000;

    // pin synchronisers, two stages each
    always_ff @(posedge i_clk_sys) begin
      load_s1  <= i_load_pin[a];
      load_s2  <= load_s1;
      fault_s1 <= i_fault_pin[a];
      fault_s2 <= fault_s1;
      enc_s1   <= {i_enc_a[a], i_enc_b[a]};
      enc_s2   <= enc_s1;
    end

    // load word: taken only when two samples agree, so a word caught in
    // mid-change never mixes bits of two values
    always_ff @(posedge i_clk_sys) begin
      load_s3 <= load_s2;
      if (load_s2 == load_s3) begin
        load_val <= load_s3;
      end
    end

    // software-written configuration
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        full_steps <= `FULL_STEPS_RST;
        freewheel  <= `FREEWHEEL_RST;
        enc_res    <= `ENC_RES_RST;
        max_dev    <= `MAX_DEV_RST;
        group_reg  <= `GROUP_RST;
        pd_delay   <= `PD_DELAY_RST;
        shaft_inv  <= `SHAFT_INV_RST;
        unit_pps   <= `UNIT_MODE_RST;
      end else if (sel) begin
        if (idx_hit(a_idx, `IDX_FULL_STEPS)) full_steps <= m_steps[15:0];
        if (idx_hit(a_idx, `IDX_FREEWHEEL))  freewheel  <= wdata[1:0];
        if (idx_hit(a_idx, `IDX_ENC_RES))    enc_res    <= m_res[15:0];
        if (idx_hit(a_idx, `IDX_MAX_DEV))    max_dev    <= m_dev[15:0];
        if (idx_hit(a_idx, `IDX_GROUP))      group_reg  <= wdata[7:0];
        if (idx_hit(a_idx, `IDX_PD_DELAY))   pd_delay   <= m_delay[8:0];
        if (idx_hit(a_idx, `IDX_SHAFT_INV))  shaft_inv  <= wdata[0];
        if (idx_hit(a_idx, `IDX_UNIT_MODE))  unit_pps   <= wdata[0];
      end
    end

    // encoder counter: software write wins over a pin step
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        enc_count <= 32'h0000_0000;
        enc_prev  <= 2'h0;
      end else begin
        enc_prev <= enc_s2;
        if (sel && idx_hit(a_idx, `IDX_ENC_COUNT)) begin
          enc_count <= be_merge(enc_count, wdata, i_avs_byteenable);
        end else if (enc_step) begin
          enc_count <= enc_up ? enc_count + 32'h0000_0001
                              : enc_count - 32'h0000_0001;
        end
      end
    end

    // sticky error flags: events set over read or command clear
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        err_flags  <= 2'h0;
        stall_prev <= 1'b0;
        dev_over_q <= 1'b0;
      end else begin
        stall_prev <= fault_s2[0];
        dev_over_q <= dev_over;
        err_flags  <= ((clr_read || cmd_hit) ? 2'h0 : err_flags) | err_set;
      end
    end

    // outgoing command: a deviation halt takes the slot
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        o_axis_cmd[a] <= '{valid: 1'b0, code: axis_supervision_pkg::no_cmd};
      end else if (dev_trip[a]) begin
        o_axis_cmd[a] <= '{valid: 1'b1, code: axis_supervision_pkg::motor_halt_cmd};
      end else if (cmd_hit) begin
        o_axis_cmd[a] <= '{valid: 1'b1, code: i_cmd.code};
      end else begin
        o_axis_cmd[a] <= '{valid: 1'b0, code: axis_supervision_pkg::no_cmd};
      end
    end

    // standstill timer, counted in 10 ms ticks
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || !i_standstill[a]) begin
        pd_cnt          <= 9'h000;
        o_power_down[a] <= 1'b0;
      end else if (pd_cnt >= pd_delay) begin
        o_power_down[a] <= 1'b1;
      end else if (pd_tick) begin
        pd_cnt <= pd_cnt + 9'h001;
      end
    end

    assign o_axis_cfg[a] = '{full_steps: full_steps, enc_res: enc_res,
                             freewheel: freewheel, shaft_inv: shaft_inv,
                             unit_pps: unit_pps};

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    chk_steps_default: assert property (@(posedge i_clk_sys)
      $fell(i_sys_rst) |-> (full_steps == `FULL_STEPS_RST))
      else $error("full step default wrong");
    chk_pd_default: assert property (@(posedge i_clk_sys)
      $fell(i_sys_rst) |-> (pd_delay == `PD_DELAY_RST))
      else $error("power-down delay default wrong");
    chk_unit_default: assert property (@(posedge i_clk_sys)
      $fell(i_sys_rst) |-> unit_pps)
      else $error("unit mode default wrong");
    chk_err_read_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (clr_read && (err_set == 2'h0)) |=> (err_flags == 2'h0))
      else $error("error flags survived a read");
    chk_err_cmd_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (cmd_hit && (err_set == 2'h0)) |=> (err_flags == 2'h0))
      else $error("error flags survived a command");
    chk_dev_flag: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      dev_trip[a] |=> err_flags[`ERR_DEV_BIT])
      else $error("deviation flag not set");
    chk_dev_halt: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      dev_trip[a] |=> (o_axis_cmd[a].valid
                       && (o_axis_cmd[a].code == axis_supervision_pkg::motor_halt_cmd)))
      else $error("deviation did not halt the motor");
    chk_dev_disabled: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (max_dev == 16'h0000) |-> !dev_over)
      else $error("supervision active with zero limit");
    chk_group_fanout: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_cmd.valid && (i_cmd.code != axis_supervision_pkg::no_cmd) && (group_id[a] != 8'h00)
       && (group_id[a] == src_group)) |=> o_axis_cmd[a].valid)
      else $error("group member missed a command");
    chk_group_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_cmd.valid && (i_cmd.axis != AX) && (group_id[a] == 8'h00) && !dev_trip[a])
      |=> !o_axis_cmd[a].valid)
      else $error("ungrouped axis took a foreign command");
    chk_pd_timing: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      $rose(o_power_down[a]) |-> ($past(pd_cnt) >= pd_delay) && $past(i_standstill[a]))
      else $error("power-down before the delay ran out");
  end : g_axis

endmodule : axis_supervision

/* testbench/axis_drv_model.sv */
/*
  motor driver and encoder model: quadrature encoder lines and driver fault pins.
  assumes: bench pulses i_step for one cycle, at least four cycles apart.
*/
module axis_drv_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_step,
  input  wire logic       i_dir,
  input  wire logic [7:0] i_fault,
  output logic            o_enc_a,
  output logic            o_enc_b,
  output logic [7:0]      o_fault_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase = 2'h0;  // binary position of the encoder disc
  // one quadrature state per step, up when i_dir is high
  always_ff @(posedge i_clk_sys) begin
    if (i_step) phase <= i_dir ? phase + 2'h1 : phase - 2'h1;
  end
  assign o_enc_a     = phase[0] ^ phase[1];
  assign o_enc_b     = phase[1];
  assign o_fault_pin = i_fault;  // stall, overtemperature, pre-warning, short a
endmodule : axis_drv_model

/* testbench/tb.sv */
/*
  bench for axis_supervision: registers, faults, encoder, deviation, groups, power-down.
  assumes: design files compiled first; register header on the include path.
*/
`include "axis_supervision_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, rq = 1'b0, wq = 1'b0, stp = 1'b0, dir = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [31:0] wd = 32'h0, rd, q;
  logic [2:0][31:0] pos = '0;
  logic [2:0] still = 3'h0, pdn;
  logic [2:0][9:0] load = '0;
  logic [7:0] flt = 8'h0, mf;
  logic wreq, irq, ma, mb;
  axis_supervision_pkg::motion_req_s cmd_in = '0;
  axis_supervision_pkg::axis_cmd_s [2:0] acmd;
  axis_supervision_pkg::axis_cfg_s [2:0] cfg;
  int fail_count = 0, checks_done = 0, cyc = 0;
  always #50 clk = ~clk;
  axis_drv_model u_drv (.i_clk_sys(clk), .i_step(stp), .i_dir(dir), .i_fault(flt),
    .o_enc_a(ma), .o_enc_b(mb), .o_fault_pin(mf));
  axis_supervision #(.NUM_AXES(3), .TICK_CYCLES(10)) u_dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_avs_address(adr), .i_avs_read(rq), .i_avs_write(wq), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rd), .o_avs_waitrequest(wreq), .i_cmd(cmd_in),
    .i_cmd_pos(pos), .i_standstill(still), .o_axis_cmd(acmd), .o_axis_cfg(cfg),
    .o_power_down(pdn), .i_load_pin(load), .i_fault_pin({16'h0, mf}),
    .i_enc_a({2'h0, ma}), .i_enc_b({2'h0, mb}), .o_irq(irq));
  task results;
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // avalon cycle: hold until waitrequest low, take data at that edge
  task bus(input logic w, input logic [1:0] ax, input logic [9:0] ix, input logic [31:0] d);
    @(posedge clk);
    adr <= {ax, ix, 2'h0}; wd <= d; wq <= w; rq <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rd;
    wq <= 1'b0; rq <= 1'b0;
  endtask : bus
  task rdc(input logic [1:0] ax, input logic [9:0] ix, input logic [31:0] e);
    bus(1'b0, ax, ix, 32'h0);
    chk(q, e);
  endtask : rdc
  // command pulse to one axis, then look at axis ob in the answer cycle
  task cmd(input logic [1:0] ax, input logic [2:0] c, input int ob, input logic ev);
    @(posedge clk) cmd_in <= '{1'b1, ax, axis_supervision_pkg::motion_cmd_e'(c)};
    @(posedge clk) cmd_in <= '0;
    @(negedge clk) chk({acmd[ob].valid, acmd[ob].code & {3{acmd[ob].valid}}}, {ev, c & {3{ev}}});
  endtask : cmd
  task steps(input int n, input logic d);
    repeat (n) begin
      @(posedge clk) begin stp <= 1'b1; dir <= d; end
      @(posedge clk) stp <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : steps
  // watch axis 0 for a halt pulse over eight cycles
  task halt_wait(input logic ev);
    logic seen;
    seen = 1'b0;
    repeat (8) @(negedge clk) seen |= acmd[0].valid && acmd[0].code === axis_supervision_pkg::motor_halt_cmd;
    chk(seen, ev);
  endtask : halt_wait
  task t_regs;
    rdc(0, `IDX_FULL_STEPS, 32'hC8);
    rdc(0, `IDX_PD_DELAY, 32'hC8);
    rdc(1, `IDX_UNIT_MODE, 32'h1);
    rdc(2, `IDX_GROUP, 32'h0);
    bus(1, 0, `IDX_FULL_STEPS, 32'hFFFF);
    rdc(0, `IDX_FULL_STEPS, 32'hFFFF);
    bus(1, 2, `IDX_ENC_RES, 32'hFFFF);
    rdc(2, `IDX_ENC_RES, 32'hFFFF);
    rdc(0, 10'h0C9, 32'h0);
    bus(1, 1, `IDX_SHAFT_INV, 32'h1);
    bus(1, 1, `IDX_UNIT_MODE, 32'h0);
    @(negedge clk) chk({cfg[1].shaft_inv, cfg[1].unit_pps}, 32'h2);
  endtask : t_regs
  task t_faults;
    load[0] <= 10'h3FF; flt <= 8'h0F;
    repeat (8) @(posedge clk);
    rdc(0, `IDX_LOAD, 32'h3FF);
    rdc(0, `IDX_DRV_FAULT, 32'h0F);
    bus(1, 0, `IDX_IRQ_ENABLE, 32'h1);
    @(negedge clk) chk(irq, 32'h1);
    rdc(0, `IDX_STICKY_ERR, 32'h1);
    rdc(0, `IDX_STICKY_ERR, 32'h0);
    bus(1, 0, `IDX_IRQ_CLEAR, 32'h1);
    @(negedge clk) chk(irq, 32'h0);
    @(posedge clk) flt <= 8'h0;
    repeat (8) @(posedge clk);
    flt <= 8'h1; repeat (8) @(negedge clk);
    chk(irq, 32'h1);
    cmd(0, 3'h1, 0, 1'b1);
    rdc(0, `IDX_STICKY_ERR, 32'h0);
  endtask : t_faults
  task t_enc;
    steps(4, 1'b1);
    rdc(0, `IDX_ENC_COUNT, 32'h4);
    bus(1, 0, `IDX_ENC_COUNT, 32'h1);
    steps(3, 1'b0);
    rdc(0, `IDX_ENC_COUNT, 32'hFFFFFFFE);
  endtask : t_enc
  task t_dev;
    pos[0] <= 32'h3E8;
    halt_wait(1'b0);
    rdc(0, `IDX_STICKY_ERR, 32'h0);
    pos[0] <= 32'hFFFFFFFE;
    bus(1, 0, `IDX_MAX_DEV, 32'h5);
    pos[0] <= 32'h3;
    halt_wait(1'b0);
    @(posedge clk) pos[0] <= 32'h4;
    halt_wait(1'b1);
    rdc(0, `IDX_STICKY_ERR, 32'h2);
    pos[0] <= 32'hFFFFFFFE;
  endtask : t_dev
  task t_group;
    bus(1, 0, `IDX_GROUP, 32'h1);
    bus(1, 1, `IDX_GROUP, 32'h1);
    for (int c = 1; c < 6; c++) cmd(0, c[2:0], 1, 1'b1);
    cmd(0, 3'h5, 2, 1'b0);
    cmd(2, 3'h1, 0, 1'b0);
  endtask : t_group
  task t_pd;
    bus(1, 0, `IDX_PD_DELAY, 32'h3);
    still[0] <= 1'b1;
    repeat (20) @(negedge clk);
    chk(pdn[0], 32'h0);
    repeat (25) @(negedge clk);
    chk(pdn[0], 32'h1);
    @(posedge clk) still[0] <= 1'b0;
    repeat (2) @(negedge clk);
    chk(pdn[0], 32'h0);
  endtask : t_pd
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs; t_faults; t_enc; t_dev; t_group; t_pd;
    results;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      results;
    end
  end
endmodule : tb
